/* File: ccpis_pkg.sv */
`default_nettype none
package ccpis_pkg;
  // Word indices; byte address is four times the index
  localparam logic [11:0] PWR_STS_IDX = 12'h80A;
  localparam logic [11:0] DBG_STS_IDX = 12'h80B;
  localparam logic [11:0] CC_EN_IDX = 12'h811;
  localparam logic [11:0] PWR_MASK_IDX = 12'h820;
  localparam logic [11:0] DBG_MASK_IDX = 12'h821;
  localparam logic [11:0] CTRL_IDX = 12'h822;
  localparam int IDX_W = 12;
  // Power status bit positions
  localparam int PWR_VBUS_VLD = 7;
  localparam int PWR_VCONN_DERR = 6;
  localparam int PWR_CC2_BD = 5;
  localparam int PWR_VBUS_TMO = 4;
  localparam int PWR_VCONN2_ON = 3;
  localparam int PWR_VCONN1_ON = 2;
  localparam int PWR_CC1_BD = 1;
  localparam int PWR_VCONN_OC = 0;
  // Debug status bit positions
  localparam int DBG_VCONN_DCH = 3;
  localparam int DBG_VBUS_DCH = 2;
  localparam int DBG_CFG1_DONE = 1;
  localparam int DBG_CFG0_DONE = 0;
  // Implemented bits of the 8-bit registers
  localparam logic [7:0] DBG_IMPL = 8'h0F;
  localparam logic [7:0] CC_EN_IMPL = 8'hF3;
  // Control register fields
  localparam int CTL_DFP = 0;
  localparam int CTL_DCH_LO = 1;
  localparam int CTL_VDEB = 3;
  localparam int CTL_TIME_LO = 8;
  localparam logic [31:0] CTRL_IMPL = 32'h0000_FF0F;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] REG8_RST = 8'h00;
  // Discharge control settings under which errors are tracked
  localparam logic [1:0] DCH_TRACK0 = 2'h0;
  localparam logic [1:0] DCH_TRACK1 = 2'h1;
  // Discharge monitor states, Gray along idle-timing-flagged
  typedef enum logic [1:0] {
    CCPIS_IDLE = 2'b00,
    CCPIS_TIMING = 2'b01,
    CCPIS_FLAGGED = 2'b11
  } ccpis_dch_e;
endpackage
`default_nettype wire

/* File: ccpis_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ccpis_top #(
  parameter int ADDR_W = 16, // APB address width
  parameter int TIME_W = 8 // Discharge time limit width
) (
  input wire logic clk, // 10 MHz clock
  input wire logic nrst, // Async reset, low
  input wire logic en, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic vbus_threshold_match_valid_flag, // Match result valid
  input wire logic vconn_above_limit, // VCONN at/above limit
  input wire logic cc2_backdrive, // CC2 back-drive level
  input wire logic timeout_a, // Timeout_a timeout pulse
  input wire logic vconn2_powering, // Second switch on
  input wire logic vconn1_powering, // First switch on
  input wire logic cc1_backdrive, // CC1 back-drive level
  input wire logic vconn_overcurrent, // Over-current level
  input wire logic vconn_discharging_flag, // VCONN discharge
  input wire logic vbus_discharging_flag, // VBUS discharge
  input wire logic cfg1_done, // Second pin sampled pulse
  input wire logic cfg0_done, // First pin sampled pulse
  input wire logic [7:0] cc_events, // Raw CC interrupt events
  output logic standalone_dfp, // DFP mode from control
  output logic vbus_deb_en, // VBUS debouncer enable
  output logic cc_irq, // Masked CC interrupt
  output logic irq // Combined interrupt level
);

  // Refuse an address too narrow for the register indices
  if (ADDR_W < ccpis_pkg::IDX_W + 2)
  begin : g_chk_addr
    $error("ADDR_W too small");
  end
  if (TIME_W < 1 || TIME_W > 8)
  begin : g_chk_time
    $error("TIME_W must be 1..8");
  end

  // Register state
  logic [7:0] pwr_sts_ff; // Power event status
  logic [7:0] dbg_sts_ff; // Debug event status
  logic [7:0] pwr_mask_ff; // Power interrupt mask
  logic [7:0] dbg_mask_ff; // Debug interrupt mask
  logic [7:0] cc_en_ff; // CC interrupt enable
  logic [31:0] ctrl_ff; // Mode and discharge control
  logic [31:0] prdata_ff; // Registered read data
  logic vdeb_q_ff; // Debouncer enable, last cycle
  logic vld_armed_ff; // Waiting for first valid match
  logic vld_done_ff; // First valid match already reported
  ccpis_pkg::ccpis_dch_e dch_state_ff; // VCONN discharge monitor state
  ccpis_pkg::ccpis_dch_e nxt_dch_state; // Next monitor state
  logic [TIME_W-1:0] dch_cnt_ff; // Cycles spent discharging
  logic cc_irq_ff; // Registered CC interrupt
  logic irq_ff; // Registered combined interrupt

  // Bus decode
  logic [ADDR_W-3:0] word_idx; // Word index from byte address
  logic aligned; // Byte-lane bits are zero
  logic setup_ph; // First cycle of a transfer
  logic access_ph; // Completing cycle of a transfer
  logic hit_pwr_sts; // Power status selected
  logic hit_dbg_sts; // Debug status selected
  logic hit_cc_en; // CC enable selected
  logic hit_pwr_mask; // Power mask selected
  logic hit_dbg_mask; // Debug mask selected
  logic hit_ctrl; // Control selected
  logic hit_any; // Some register selected
  logic wr_strobe; // Write takes effect this edge
  logic [31:0] rd_val; // Read mux output

  // Event sources and control fields
  logic [7:0] pwr_set; // Power bits set this cycle
  logic [7:0] dbg_set; // Debug bits set this cycle
  logic [7:0] pwr_clr; // Power bits cleared by write
  logic [7:0] dbg_clr; // Debug bits cleared by write
  logic dfp_mode; // Standalone DFP selected
  logic [1:0] dch_ctl; // VCONN discharge control setting
  logic dch_track; // Discharge errors are tracked
  logic dch_active; // A tracked discharge is running
  logic [TIME_W-1:0] dch_limit; // Programmed discharge time
  logic deb_rise; // Debouncer enable just went high
  logic vld_event; // First valid match seen
  logic dch_err_set; // Discharge error detected now

  // Address decode; unaligned byte addresses select nothing
  assign word_idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign hit_pwr_sts = aligned && (word_idx == (ADDR_W-2)'(ccpis_pkg::PWR_STS_IDX));
  assign hit_dbg_sts = aligned && (word_idx == (ADDR_W-2)'(ccpis_pkg::DBG_STS_IDX));
  assign hit_cc_en = aligned && (word_idx == (ADDR_W-2)'(ccpis_pkg::CC_EN_IDX));
  assign hit_pwr_mask = aligned && (word_idx == (ADDR_W-2)'(ccpis_pkg::PWR_MASK_IDX));
  assign hit_dbg_mask = aligned && (word_idx == (ADDR_W-2)'(ccpis_pkg::DBG_MASK_IDX));
  assign hit_ctrl = aligned && (word_idx == (ADDR_W-2)'(ccpis_pkg::CTRL_IDX));
  assign hit_any = hit_pwr_sts || hit_dbg_sts || hit_cc_en || hit_pwr_mask || hit_dbg_mask || hit_ctrl;

  // Zero wait states: read data was already latched in the setup cycle
  assign pready = access_ph;
  // Unmapped words answer with an error and change nothing
  assign pslverr = access_ph && !hit_any;
  assign wr_strobe = access_ph && pwrite && hit_any;
  assign prdata = prdata_ff;

  // Read mux; reserved bits read as zero
  always_comb
  begin
    rd_val = 32'h0000_0000; // Unmapped reads return zero
    if (hit_pwr_sts)
      rd_val = 32'(pwr_sts_ff);
    else if (hit_dbg_sts)
      rd_val = 32'(dbg_sts_ff);
    else if (hit_cc_en)
      rd_val = 32'(cc_en_ff);
    else if (hit_pwr_mask)
      rd_val = 32'(pwr_mask_ff);
    else if (hit_dbg_mask)
      rd_val = 32'(dbg_mask_ff);
    else if (hit_ctrl)
      rd_val = ctrl_ff;
  end

  // Read data captured at setup; an event on that same edge shows on the next read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prdata_ff <= 32'h0000_0000;
    else if (en && setup_ph && !pwrite)
      prdata_ff <= rd_val;
  end

  // Control register: mode, discharge control, debouncer enable, discharge time
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_ff <= ccpis_pkg::CTRL_RST;
    else if (en && wr_strobe && hit_ctrl)
      ctrl_ff <= pwdata & ccpis_pkg::CTRL_IMPL;
  end

  // Control fields
  assign dfp_mode = ctrl_ff[ccpis_pkg::CTL_DFP];
  assign dch_ctl = ctrl_ff[ccpis_pkg::CTL_DCH_LO +: 2];
  assign dch_track = (dch_ctl == ccpis_pkg::DCH_TRACK0) || (dch_ctl == ccpis_pkg::DCH_TRACK1);
  assign dch_limit = ctrl_ff[ccpis_pkg::CTL_TIME_LO +: TIME_W];
  assign standalone_dfp = dfp_mode;
  assign vbus_deb_en = ctrl_ff[ccpis_pkg::CTL_VDEB];

  // Interrupt masks and CC enables; unimplemented bits stay zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwr_mask_ff <= ccpis_pkg::REG8_RST;
      dbg_mask_ff <= ccpis_pkg::REG8_RST;
      cc_en_ff <= ccpis_pkg::REG8_RST;
    end
    else if (en && wr_strobe)
    begin
      if (hit_pwr_mask)
        pwr_mask_ff <= pwdata[7:0];
      if (hit_dbg_mask)
        dbg_mask_ff <= pwdata[7:0] & ccpis_pkg::DBG_IMPL;
      if (hit_cc_en)
        cc_en_ff <= pwdata[7:0] & ccpis_pkg::CC_EN_IMPL;
    end
  end

  // First valid match after the debouncer is first enabled; reported once per reset
  assign deb_rise = vbus_deb_en && !vdeb_q_ff;
  assign vld_event = (vld_armed_ff || deb_rise) && !vld_done_ff && vbus_threshold_match_valid_flag;

  // Debouncer enable history and arming
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vdeb_q_ff <= 1'b0;
      vld_armed_ff <= 1'b0;
      vld_done_ff <= 1'b0;
    end
    else if (en)
    begin
      vdeb_q_ff <= vbus_deb_en;
      if (vld_event)
      begin
        vld_armed_ff <= 1'b0;
        vld_done_ff <= 1'b1;
      end
      else if (deb_rise && !vld_done_ff)
        vld_armed_ff <= 1'b1;
    end
  end

  // Discharge watched only in standalone DFP with a tracked control setting
  assign dch_active = dfp_mode && dch_track && vconn_discharging_flag;
  // Error once more than the time limit has passed with VCONN still high
  assign dch_err_set = (dch_state_ff == ccpis_pkg::CCPIS_TIMING) && dch_active
    && (dch_cnt_ff == dch_limit) && vconn_above_limit;

  // Monitor next state; FLAGGED means the check is done for this discharge
  always_comb
  begin
    nxt_dch_state = dch_state_ff;
    case (dch_state_ff)
      ccpis_pkg::CCPIS_IDLE:
        if (dch_active)
          nxt_dch_state = ccpis_pkg::CCPIS_TIMING;
      ccpis_pkg::CCPIS_TIMING:
        if (!dch_active)
          nxt_dch_state = ccpis_pkg::CCPIS_IDLE;
        else if (dch_cnt_ff == dch_limit)
          nxt_dch_state = ccpis_pkg::CCPIS_FLAGGED;
      ccpis_pkg::CCPIS_FLAGGED:
        if (!dch_active)
          nxt_dch_state = ccpis_pkg::CCPIS_IDLE;
      default:
        nxt_dch_state = ccpis_pkg::CCPIS_IDLE;
    endcase
  end

  // Monitor state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dch_state_ff <= ccpis_pkg::CCPIS_IDLE;
    else if (en)
      dch_state_ff <= nxt_dch_state;
  end

  // Discharge timer in enabled cycles; restarts from zero on each entry
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dch_cnt_ff <= '0;
    else if (en && dch_state_ff == ccpis_pkg::CCPIS_TIMING)
      dch_cnt_ff <= dch_cnt_ff + TIME_W'(1);
    else if (en)
      dch_cnt_ff <= '0;
  end

  // Sources set while high, so a level source re-sets its bit after a clear
  always_comb
  begin
    pwr_set = ccpis_pkg::REG8_RST;
    pwr_set[ccpis_pkg::PWR_VBUS_VLD] = vld_event;
    pwr_set[ccpis_pkg::PWR_VCONN_DERR] = dch_err_set;
    pwr_set[ccpis_pkg::PWR_CC2_BD] = cc2_backdrive;
    pwr_set[ccpis_pkg::PWR_VBUS_TMO] = timeout_a;
    pwr_set[ccpis_pkg::PWR_VCONN2_ON] = vconn2_powering;
    pwr_set[ccpis_pkg::PWR_VCONN1_ON] = vconn1_powering;
    pwr_set[ccpis_pkg::PWR_CC1_BD] = cc1_backdrive;
    pwr_set[ccpis_pkg::PWR_VCONN_OC] = vconn_overcurrent;
    dbg_set = ccpis_pkg::REG8_RST;
    dbg_set[ccpis_pkg::DBG_VCONN_DCH] = dfp_mode && vconn_discharging_flag;
    dbg_set[ccpis_pkg::DBG_VBUS_DCH] = vbus_discharging_flag;
    dbg_set[ccpis_pkg::DBG_CFG1_DONE] = cfg1_done;
    dbg_set[ccpis_pkg::DBG_CFG0_DONE] = cfg0_done;
  end

  // Write-one-to-clear masks; zeros leave bits alone
  assign pwr_clr = (wr_strobe && hit_pwr_sts) ? pwdata[7:0] : ccpis_pkg::REG8_RST;
  assign dbg_clr = (wr_strobe && hit_dbg_sts) ? pwdata[7:0] : ccpis_pkg::REG8_RST;

  // Power status; a set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pwr_sts_ff <= ccpis_pkg::REG8_RST;
    else if (en)
    begin
      pwr_sts_ff <= (pwr_sts_ff & ~pwr_clr) | pwr_set;
      if (!dfp_mode)
        pwr_sts_ff[ccpis_pkg::PWR_VCONN_DERR] <= 1'b0;
    end
  end

  // Debug status; upper nibble reserved, bit 3 exists only in DFP
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dbg_sts_ff <= ccpis_pkg::REG8_RST;
    else if (en)
    begin
      dbg_sts_ff <= ((dbg_sts_ff & ~dbg_clr) | dbg_set) & ccpis_pkg::DBG_IMPL;
      if (!dfp_mode)
        dbg_sts_ff[ccpis_pkg::DBG_VCONN_DCH] <= 1'b0;
    end
  end

  // Interrupt outputs registered so they never glitch, at one cycle of latency
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cc_irq_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else if (en)
    begin
      cc_irq_ff <= |(cc_events & cc_en_ff);
      irq_ff <= (|(pwr_sts_ff & pwr_mask_ff)) || (|(dbg_sts_ff & dbg_mask_ff)) || (|(cc_events & cc_en_ff));
    end
  end
  assign cc_irq = cc_irq_ff;
  assign irq = irq_ff;

  // Checks share the one clock; reset disables them
  default clocking dflt_cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  lvl_reset_a: assert property (en && cc1_backdrive |=> pwr_sts_ff[ccpis_pkg::PWR_CC1_BD])
    else $error("level source did not set its status bit");
  pulse_set_a: assert property (en && timeout_a |=> pwr_sts_ff[ccpis_pkg::PWR_VBUS_TMO])
    else $error("timeout pulse did not set its status bit");
  w1c_clear_a: assert property (en && wr_strobe && hit_pwr_sts && pwdata[ccpis_pkg::PWR_VBUS_TMO] && !timeout_a
    |=> !pwr_sts_ff[ccpis_pkg::PWR_VBUS_TMO])
    else $error("write of one did not clear status bit");
  dfp_only_a: assert property (en && !dfp_mode |=> !pwr_sts_ff[ccpis_pkg::PWR_VCONN_DERR])
    else $error("discharge error bit set outside DFP mode");
  dbg_rsv_a: assert property ((dbg_sts_ff & ~ccpis_pkg::DBG_IMPL) == ccpis_pkg::REG8_RST)
    else $error("reserved debug status bits set");
  cc_rsv_a: assert property ((cc_en_ff & ~ccpis_pkg::CC_EN_IMPL) == ccpis_pkg::REG8_RST)
    else $error("reserved CC enable bits set");
  track_off_a: assert property (en && !dch_track |=> dch_state_ff == ccpis_pkg::CCPIS_IDLE)
    else $error("discharge monitored with untracked setting");
  vbus_dch_a: assert property (en && vbus_discharging_flag |=> dbg_sts_ff[ccpis_pkg::DBG_VBUS_DCH])
    else $error("VBUS discharge level did not set its bit");

  // Main scenarios
  vld_seen_c: cover property (vld_event);
  dch_err_c: cover property (dch_err_set);
  cc_irq_c: cover property (cc_irq_ff);
  w1c_c: cover property (wr_strobe && hit_pwr_sts && (|(pwr_clr & pwr_sts_ff)));
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se, cc_irq, irq, dfp, vde;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [11:0] src = 12'h000; // Event sources, power bits in 7:0
  logic [7:0] cc_ev = 8'h00;
  int fails = 0, tests_run = 0, cyc = 0;
  always #50 clk = ~clk;
  ccpis_top DUT (.clk(clk), .nrst(nrst), .en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vbus_threshold_match_valid_flag(src[7]), .vconn_above_limit(src[6]), .cc2_backdrive(src[5]),
    .timeout_a(src[4]), .vconn2_powering(src[3]), .vconn1_powering(src[2]), .cc1_backdrive(src[1]),
    .vconn_overcurrent(src[0]), .vconn_discharging_flag(src[11]), .vbus_discharging_flag(src[10]),
    .cfg1_done(src[9]), .cfg0_done(src[8]), .cc_events(cc_ev), .standalone_dfp(dfp), .vbus_deb_en(vde),
    .cc_irq(cc_irq), .irq(irq));
  // Compare and count
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; request held until pready sampled high
  task acc(input logic w, input logic [11:0] i, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= 16'({i, 2'b00}); pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata; se = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard, far above the expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("pwr_rst", q, 0);
    src <= 12'h42F; // Level sources held
    acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("pwr_lvl", q, 32'h2F);
    acc(1, ccpis_pkg::PWR_STS_IDX, 32'hFF); acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("pwr_reset", q, 32'h2F);
    src <= 12'h000; acc(1, ccpis_pkg::PWR_STS_IDX, 32'h0F);
    acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("pwr_w0", q, 32'h20);
    acc(1, ccpis_pkg::PWR_STS_IDX, 32'hFF); acc(0, ccpis_pkg::DBG_STS_IDX, 0); chk("dbg_vbus", q, 32'h4);
    acc(1, ccpis_pkg::DBG_STS_IDX, 32'hFF); @(posedge clk) src <= 12'h310; @(posedge clk) src <= 12'h000;
    acc(0, ccpis_pkg::DBG_STS_IDX, 0); chk("dbg_done", q, 32'h3);
    acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("pwr_tmo", q, 32'h10);
    acc(1, ccpis_pkg::PWR_STS_IDX, 32'hFF); acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("pwr_pulse", q, 0);
    acc(1, ccpis_pkg::CTRL_IDX, 32'h8); src <= 12'h080; acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("vld", q, 32'h80);
    chk("deb_en", vde, 1);
    acc(1, ccpis_pkg::PWR_MASK_IDX, 32'h80); repeat (2) @(posedge clk); chk("irq_on", irq, 1);
    acc(1, ccpis_pkg::PWR_MASK_IDX, 32'h0); repeat (2) @(posedge clk); chk("irq_off", irq, 0);
    acc(1, ccpis_pkg::CC_EN_IDX, 32'hFF); acc(0, ccpis_pkg::CC_EN_IDX, 0); chk("cc_en", q, 32'hF3);
    cc_ev <= 8'h0C; repeat (2) @(posedge clk); chk("cc_rsv", cc_irq, 0);
    cc_ev <= 8'h81; repeat (2) @(posedge clk); chk("cc_irq", cc_irq, 1);
    // DFP mode, tracked setting, limit of 4 cycles, VCONN stays high
    acc(1, ccpis_pkg::PWR_STS_IDX, 32'hFF); acc(1, ccpis_pkg::DBG_STS_IDX, 32'hFF);
    acc(1, ccpis_pkg::CTRL_IDX, 32'h0000_0409); src <= 12'h840; repeat (10) @(posedge clk);
    chk("dfp", dfp, 1);
    acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("vconn_err", q, 32'h40);
    acc(0, ccpis_pkg::DBG_STS_IDX, 0); chk("vconn_dch", q, 32'h8);
    // Untracked discharge control setting
    acc(1, ccpis_pkg::CTRL_IDX, 32'h0000_0405); acc(1, ccpis_pkg::PWR_STS_IDX, 32'hFF); repeat (10) @(posedge clk);
    acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("no_track", q, 0);
    // Not DFP: both DFP-only bits stay reserved
    acc(1, ccpis_pkg::CTRL_IDX, 32'h0000_0408); acc(1, ccpis_pkg::PWR_STS_IDX, 32'hFF);
    acc(1, ccpis_pkg::DBG_STS_IDX, 32'hFF); repeat (10) @(posedge clk);
    acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("ufp_err", q, 0);
    acc(0, ccpis_pkg::DBG_STS_IDX, 0); chk("ufp_dch", q, 0);
    // VCONN falls in time: no error
    acc(1, ccpis_pkg::CTRL_IDX, 32'h0000_0403); src <= 12'h800; repeat (10) @(posedge clk);
    acc(0, ccpis_pkg::PWR_STS_IDX, 0); chk("below_lim", q, 0);
    src <= 12'h000;
    acc(0, 12'h700, 0); chk("unmapped", se, 1);
    finish_test();
  end
endmodule
`default_nettype wire
